// ### logic/sq_seq.v
// Soft-start, pre-bias, power-good and output fault sequencer
`timescale 1ns/1ps
`include "sq_seq_defines.vh"

// How it works
// - No switching until soft-start reference exceeds sensed output.
// - Pre-charged output up to full target starts monotonically, never discharged.
// - Strap decodes light-load enable, soft-start clock and matching hiccup time.
// - Strap shorted to ground gives 1 MHz, 25.2 ms hiccup, light load off.
// - Host may set clock, light-load enable and hiccup instead of strap.
// - Soft-start time scales with output range and doubles per clock halving.
// - Power-good is open-drain, released during normal regulation.
// - Power-good warning when output outside the warning window.
// - Power-good low on fault, soft start, shutdown and programming mode.
// - Power-good released only after delay with no forcing-low condition.
// - Overvoltage ends switching cycle and turns on low-side switch.
// - Low side on until negative limit, then off 2000 ns, repeat.
// - Discharge pulsing continues until undervoltage, then hiccup wait.
// - Undervoltage stops conversion and enters hiccup wait before retry.
// - Power-good delay after soft start is 500 microseconds.
// - Forced continuous conduction always used during soft start.
// - Light-load pulse mode starts only after power-good is asserted.
module sq_seq #(
  parameter PG_DELAY_CYC  = `SQ_PG_DELAY_CYC,
  parameter SS_BASE_TICKS = `SQ_SS_BASE_TICKS,
  parameter HICCUP_TICKS  = `SQ_HICCUP_TICKS
) (
  input  wire       sys_clk,
  input  wire       rst_b,
  input  wire       enable_in,
  input  wire       program_mode_in,
  input  wire [3:0] softstart_lightload_strap,
  input  wire       host_cfg_valid,
  input  wire       host_light_load_en,
  input  wire [1:0] host_ssclk_sel,
  input  wire [1:0] vout_range_sel,
  input  wire       ss_ref_above_sense,
  input  wire       overvoltage_trip,
  input  wire       undervoltage_trip,
  input  wire       ov_warn,
  input  wire       uv_warn,
  input  wire       neg_ilim_hit,
  output reg        high_side_en_q,
  output reg        low_side_en_q,
  output reg        ss_ramp_active_q,
  output reg        forced_continuous_mode_q,
  output reg        light_load_pulse_mode_q,
  output reg        hiccup_active_q,
  output reg        pg_warning_q,
  output reg        output_good_flag_out_q,
  output reg        output_good_flag_oe_n_q
);

  // ==========================================================
  // States
  localparam [2:0] ST_OFF    = 3'h0;
  localparam [2:0] ST_SOFT   = 3'h1;
  localparam [2:0] ST_RUN    = 3'h2;
  localparam [2:0] ST_OVDIS  = 3'h3;
  localparam [2:0] ST_HICCUP = 3'h4;

  localparam [31:0] SS_BASE_W   = SS_BASE_TICKS;
  localparam [31:0] HICC_LAST_W = HICCUP_TICKS - 1;
  localparam [31:0] PG_LAST_W   = PG_DELAY_CYC - 1;
  localparam [31:0] OV_OFF_W    = `SQ_OV_OFF_CYC;
  localparam [15:0] SS_BASE     = SS_BASE_W[15:0];
  localparam [15:0] HICC_LAST   = HICC_LAST_W[15:0];
  localparam [15:0] PG_LAST     = PG_LAST_W[15:0];
  localparam [7:0]  OV_OFF      = OV_OFF_W[7:0];

  // ==========================================================
  // Strap decode: {light load enable, clock select}
  function [2:0] strap_decode;
    input [3:0] code;
    begin
      if (code >= `SQ_STRAP_LL_FIRST && code <= `SQ_STRAP_LL_LAST)
        strap_decode = {1'b1, code[1:0] - 2'h1};
      else if (code >= `SQ_STRAP_NOLL_FIRST && code <= `SQ_STRAP_NOLL_LAST)
        strap_decode = {1'b0, code[1:0] - 2'h1};
      else
        strap_decode = {1'b0, `SQ_SSCLK_SEL_DEFAULT};
    end
  endfunction

  reg  [2:0]  state_q;
  reg  [1:0]  clk_sel_q;
  reg         ll_en_q;
  reg  [15:0] ss_len_q;
  reg  [15:0] tick_cnt_q;
  reg  [15:0] pg_cnt_q;
  reg  [7:0]  ov_off_cnt_q;
  reg         ov_ls_off_q;
  wire        ss_tick;
  wire [2:0]  strap_cfg;
  wire        conv_allowed;
  wire        pg_hold_low;
  wire        ramp_clear;

  assign strap_cfg    = strap_decode(softstart_lightload_strap);
  assign conv_allowed = enable_in && !program_mode_in;
  assign pg_hold_low  = (state_q != ST_RUN) || ov_warn || uv_warn;
  // Comparator only counts once the ramp-active flag has started the ramp
  assign ramp_clear   = ss_ramp_active_q && ss_ref_above_sense && !overvoltage_trip;

  sq_ss_tick u_tick (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_sel (clk_sel_q),
    .tick_q  (ss_tick)
  );

  // ==========================================================
  // Main sequence
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q      <= ST_OFF;
      clk_sel_q    <= `SQ_SSCLK_SEL_DEFAULT;
      ll_en_q      <= 1'b0;
      ss_len_q     <= 16'h0000;
      tick_cnt_q   <= 16'h0000;
      ov_off_cnt_q <= 8'h00;
      ov_ls_off_q  <= 1'b0;
    end else if (!conv_allowed) begin
      state_q    <= ST_OFF;
      tick_cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        ST_OFF: begin
          // Configuration is frozen once conversion begins
          if (host_cfg_valid) begin
            clk_sel_q <= host_ssclk_sel;
            ll_en_q   <= host_light_load_en;
          end else begin
            clk_sel_q <= strap_cfg[1:0];
            ll_en_q   <= strap_cfg[2];
          end
          case (vout_range_sel)
            `SQ_RANGE_LOW:  ss_len_q <= SS_BASE;
            `SQ_RANGE_MID:  ss_len_q <= SS_BASE << 1;
            default:        ss_len_q <= SS_BASE << 2;
          endcase
          tick_cnt_q <= 16'h0000;
          state_q    <= ST_SOFT;
        end
        ST_SOFT: begin
          // Ramp length in soft-start ticks, so halving the clock doubles time
          if (overvoltage_trip) begin
            state_q      <= ST_OVDIS;
            ov_ls_off_q  <= 1'b0;
          end else if (ss_tick) begin
            if (tick_cnt_q >= ss_len_q - 16'h0001) begin
              tick_cnt_q <= 16'h0000;
              state_q    <= ST_RUN;
            end else begin
              tick_cnt_q <= tick_cnt_q + 16'h0001;
            end
          end
        end
        ST_RUN: begin
          if (overvoltage_trip) begin
            state_q     <= ST_OVDIS;
            ov_ls_off_q <= 1'b0;
          end else if (undervoltage_trip) begin
            state_q    <= ST_HICCUP;
            tick_cnt_q <= 16'h0000;
          end
        end
        ST_OVDIS: begin
          if (undervoltage_trip) begin
            state_q    <= ST_HICCUP;
            tick_cnt_q <= 16'h0000;
          end else if (!ov_ls_off_q) begin
            if (neg_ilim_hit) begin
              ov_ls_off_q  <= 1'b1;
              ov_off_cnt_q <= 8'h00;
            end
          end else if (ov_off_cnt_q >= OV_OFF - 8'h02) begin
            // Released a cycle early: the enable flop adds the last cycle
            ov_ls_off_q <= 1'b0;
          end else begin
            ov_off_cnt_q <= ov_off_cnt_q + 8'h01;
          end
        end
        ST_HICCUP: begin
          if (ss_tick) begin
            if (tick_cnt_q >= HICC_LAST) begin
              tick_cnt_q <= 16'h0000;
              state_q    <= ST_SOFT;
            end else begin
              tick_cnt_q <= tick_cnt_q + 16'h0001;
            end
          end
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  // ==========================================================
  // Power-good delay and open-drain pin
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      pg_cnt_q                <= 16'h0000;
      pg_warning_q            <= 1'b0;
      output_good_flag_out_q  <= 1'b0;
      output_good_flag_oe_n_q <= 1'b0;
    end else begin
      pg_warning_q           <= ov_warn || uv_warn;
      output_good_flag_out_q <= 1'b0;
      if (pg_hold_low || !conv_allowed) begin
        pg_cnt_q                <= 16'h0000;
        output_good_flag_oe_n_q <= 1'b0;
      end else if (pg_cnt_q >= PG_LAST) begin
        output_good_flag_oe_n_q <= 1'b1;
      end else begin
        pg_cnt_q <= pg_cnt_q + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Power stage controls
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      high_side_en_q           <= 1'b0;
      low_side_en_q            <= 1'b0;
      ss_ramp_active_q         <= 1'b0;
      forced_continuous_mode_q <= 1'b1;
      light_load_pulse_mode_q  <= 1'b0;
      hiccup_active_q          <= 1'b0;
    end else begin
      ss_ramp_active_q <= conv_allowed && (state_q == ST_SOFT);
      hiccup_active_q  <= conv_allowed && (state_q == ST_HICCUP);
      if (!conv_allowed) begin
        high_side_en_q <= 1'b0;
        low_side_en_q  <= 1'b0;
      end else if (state_q == ST_SOFT) begin
        // Switching held off while output sits above the ramp
        high_side_en_q <= ramp_clear;
        low_side_en_q  <= ramp_clear;
      end else if (state_q == ST_RUN) begin
        high_side_en_q <= !overvoltage_trip && !undervoltage_trip;
        low_side_en_q  <= !undervoltage_trip;
      end else if (state_q == ST_OVDIS) begin
        high_side_en_q <= 1'b0;
        low_side_en_q  <= !ov_ls_off_q && !neg_ilim_hit && !undervoltage_trip;
      end else begin
        high_side_en_q <= 1'b0;
        low_side_en_q  <= 1'b0;
      end
      // Light load only once power good is released
      light_load_pulse_mode_q  <= ll_en_q && output_good_flag_oe_n_q &&
                                  (state_q == ST_RUN);
      forced_continuous_mode_q <= !(ll_en_q && output_good_flag_oe_n_q &&
                                    (state_q == ST_RUN));
    end
  end

endmodule // sq_seq

// ### logic/sq_seq_defines.vh
// Constants for the soft-start, power-good and fault sequencer
`ifndef SQ_SEQ_DEFINES_VH
`define SQ_SEQ_DEFINES_VH

// ==========================================================
// System clock
`define SQ_SYS_CLK_KHZ        50000

// ==========================================================
// Soft-start clock choices, kHz
`define SQ_SSCLK_2M_KHZ       2000
`define SQ_SSCLK_SEL_2M       2'h0
`define SQ_SSCLK_SEL_1M       2'h1
`define SQ_SSCLK_SEL_500K     2'h2
`define SQ_SSCLK_SEL_250K     2'h3
`define SQ_SSCLK_SEL_DEFAULT  2'h1
`define SQ_SSCLK_DIV_FAST     (`SQ_SYS_CLK_KHZ / `SQ_SSCLK_2M_KHZ)

// ==========================================================
// Strap codes: 0 short, 1..4 light load on, 5..8 light load off
`define SQ_STRAP_SHORT        4'h0
`define SQ_STRAP_LL_FIRST     4'h1
`define SQ_STRAP_LL_LAST      4'h4
`define SQ_STRAP_NOLL_FIRST   4'h5
`define SQ_STRAP_NOLL_LAST    4'h8

// ==========================================================
// Target output ranges
`define SQ_RANGE_LOW          2'h0
`define SQ_RANGE_MID          2'h1
`define SQ_RANGE_HIGH         2'h2

// ==========================================================
// Times and derived counts
`define SQ_SS_BASE_NS         450000
`define SQ_SS_BASE_TICKS      ((`SQ_SS_BASE_NS / 1000) * `SQ_SSCLK_2M_KHZ / 1000)
`define SQ_HICCUP_BASE_US     12600
`define SQ_HICCUP_TICKS       (`SQ_HICCUP_BASE_US * `SQ_SSCLK_2M_KHZ / 1000)
`define SQ_PG_DELAY_US        500
`define SQ_PG_DELAY_CYC       (`SQ_PG_DELAY_US * `SQ_SYS_CLK_KHZ / 1000)
`define SQ_OV_OFF_NS          2000
`define SQ_OV_OFF_CYC         ((`SQ_OV_OFF_NS * `SQ_SYS_CLK_KHZ + 999999) / 1000000)

`endif

// ### logic/sq_ss_tick.v
// Soft-start clock divider producing a one-cycle enable pulse
`timescale 1ns/1ps
`include "sq_seq_defines.vh"

module sq_ss_tick (
  input  wire       sys_clk,
  input  wire       rst_b,
  input  wire [1:0] clk_sel,
  output reg        tick_q
);

  localparam [31:0] DIV_FAST_W = `SQ_SSCLK_DIV_FAST;
  localparam [7:0]  DIV_FAST   = DIV_FAST_W[7:0];

  reg  [7:0] cnt_q;
  wire [7:0] limit;

  // Each halving of the soft-start clock doubles the divide
  assign limit = (DIV_FAST << clk_sel) - 8'h01;

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

endmodule // sq_ss_tick

// ### verification/sq_seq_assertions.sv
// Checker of switching, fault and power-good timing at the sequencer ports
`timescale 1ns/1ps
module sq_seq_assertions (
  input wire sys_clk,
  input wire rst_b,
  input wire enable_in,
  input wire program_mode_in,
  input wire ss_ref_above_sense,
  input wire overvoltage_trip,
  input wire undervoltage_trip,
  input wire neg_ilim_hit,
  input wire high_side_en_q,
  input wire low_side_en_q,
  input wire ss_ramp_active_q,
  input wire forced_continuous_mode_q,
  input wire light_load_pulse_mode_q,
  input wire hiccup_active_q,
  input wire output_good_flag_oe_n_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire run_ok  = enable_in && !program_mode_in;
  wire sw_off  = !high_side_en_q && !low_side_en_q;
  wire ls_only = low_side_en_q && !high_side_en_q;
  property p_no_switch; ss_ramp_active_q && !ss_ref_above_sense ##1 ss_ramp_active_q |-> sw_off; endproperty
  a_no_switch: assert property (p_no_switch) else $error("switching below ramp");
  property p_pg_off; !run_ok [*2] |=> !output_good_flag_oe_n_q; endproperty
  a_pg_off: assert property (p_pg_off) else $error("power good not low when off");
  property p_ov_dis; $rose(overvoltage_trip) && run_ok && !hiccup_active_q |-> ##[1:3] ls_only; endproperty
  a_ov_dis: assert property (p_ov_dis) else $error("no discharge on overvoltage");
  property p_ls_off;
    ls_only && neg_ilim_hit && run_ok && !hiccup_active_q && !ss_ramp_active_q |=>
      (!low_side_en_q throughout (1 ##98 1)) ##1 !low_side_en_q ##1
      (low_side_en_q || hiccup_active_q);
  endproperty
  a_ls_off: assert property (p_ls_off) else $error("low side off time wrong");
  property p_uv_hic;
    $rose(undervoltage_trip) && run_ok && !ss_ramp_active_q && !hiccup_active_q |->
      ##[1:3] (hiccup_active_q && sw_off);
  endproperty
  a_uv_hic: assert property (p_uv_hic) else $error("no hiccup on undervoltage");
  property p_hic_soft;
    $fell(hiccup_active_q) && run_ok |-> ##[0:2] (ss_ramp_active_q && !output_good_flag_oe_n_q);
  endproperty
  a_hic_soft: assert property (p_hic_soft) else $error("no restart after hiccup");
  property p_forced_continuous_mode_soft; ss_ramp_active_q |-> forced_continuous_mode_q && !light_load_pulse_mode_q; endproperty
  a_forced_continuous_mode_soft: assert property (p_forced_continuous_mode_soft) else $error("light load in soft start");
  property p_ll_pg; $rose(light_load_pulse_mode_q) |-> $past(output_good_flag_oe_n_q); endproperty
  a_ll_pg: assert property (p_ll_pg) else $error("light load before power good");
endmodule // sq_seq_assertions

bind sq_seq sq_seq_assertions chk_u (
  .sys_clk, .rst_b, .enable_in, .program_mode_in, .ss_ref_above_sense, .overvoltage_trip,
  .undervoltage_trip, .neg_ilim_hit, .high_side_en_q, .low_side_en_q, .ss_ramp_active_q,
  .forced_continuous_mode_q, .light_load_pulse_mode_q, .hiccup_active_q, .output_good_flag_oe_n_q
);

// ### verification/sq_stage_model.sv
// Behavioural power stage and output comparators facing the sequencer
`timescale 1ns/1ps
module sq_stage_model (
  input  wire        sys_clk,
  input  wire        high_side_en,
  input  wire        low_side_en,
  input  wire        ss_active,
  input  wire        load_en,
  input  wire  [7:0] load_val,
  output wire        ss_ref_above_sense,
  output wire        overvoltage_trip,
  output wire        undervoltage_trip,
  output wire        ov_warn,
  output wire        uv_warn,
  output wire        neg_ilim_hit,
  output logic [7:0] vout
);
  // Output level in percent of target; ramp stands for the soft-start reference
  logic [7:0] ramp   = 8'h00;
  logic [1:0] ls_cnt = 2'h0;
  wire  [7:0] ref_lvl = ss_active ? ramp : 8'h64;
  // Both switches on above a running ramp pull a pre-charged output down
  wire        sink    = low_side_en && (!high_side_en || (ss_active && vout > ref_lvl));
  initial vout = 8'h00;
  assign ss_ref_above_sense = ref_lvl > vout;
  assign overvoltage_trip   = vout > 8'h6E;
  assign undervoltage_trip  = vout < 8'h50;
  assign ov_warn            = vout > 8'h64;
  assign uv_warn            = vout < 8'h64;
  assign neg_ilim_hit       = ls_cnt == 2'h3;
  always @(posedge sys_clk) begin
    ramp   <= !ss_active ? 8'h00 : (ramp < 8'h64 ? ramp + 8'h02 : ramp);
    ls_cnt <= !low_side_en ? 2'h0 : (neg_ilim_hit ? ls_cnt : ls_cnt + 2'h1);
    if (load_en) begin
      vout <= load_val;
    end else if (high_side_en && vout < ref_lvl) begin
      vout <= (ref_lvl - vout < 8'h02) ? ref_lvl : vout + 8'h02;
    end else if (sink && vout > 8'h01) begin
      vout <= vout - 8'h02;
    end
  end
endmodule // sq_stage_model

// ### verification/testbench.sv
// Self-checking bench for the sequencer with a behavioural power stage
`timescale 1ns/1ps
module testbench;
  localparam int OUTPUT_GOOD_FLAG = 20;
  localparam int SSB = 4;
  localparam int HIC = 6;
  logic        sys_clk, rst_b, enable_in, program_mode_in, host_cfg_valid, host_light_load_en;
  logic        load_en, dropped;
  logic [3:0]  softstart_lightload_strap;
  logic [1:0]  host_ssclk_sel, vout_range_sel;
  logic [7:0]  load_val, vout, pre;
  logic [15:0] r;
  wire         ss_ref_above_sense, overvoltage_trip, undervoltage_trip, ov_warn, uv_warn;
  wire         neg_ilim_hit, high_side_en_q, low_side_en_q, ss_ramp_active_q, hiccup_active_q;
  wire         forced_continuous_mode_q, light_load_pulse_mode_q, pg_warning_q;
  wire         output_good_flag_out_q, output_good_flag_oe_n_q;
  wire         pg_pin = output_good_flag_oe_n_q ? 1'b1 : output_good_flag_out_q;
  int          num_errors = 0, compares = 0, n, per, exp_len;
  // Row: strap, host valid/light load/clock, range, expected clock select, expected light load
  logic [15:0] rows [0:11] = '{16'h0010, 16'h1041, 16'h2091, 16'h30E1, 16'h4031, 16'h5080,
                               16'h6050, 16'h7020, 16'h8070, 16'hF010, 16'h8E21, 16'h1800};
  sq_seq #(.PG_DELAY_CYC(OUTPUT_GOOD_FLAG), .SS_BASE_TICKS(SSB), .HICCUP_TICKS(HIC)) dut_u (
    .sys_clk, .rst_b, .enable_in, .program_mode_in, .softstart_lightload_strap, .host_cfg_valid,
    .host_light_load_en, .host_ssclk_sel, .vout_range_sel, .ss_ref_above_sense, .overvoltage_trip,
    .undervoltage_trip, .ov_warn, .uv_warn, .neg_ilim_hit, .high_side_en_q, .low_side_en_q,
    .ss_ramp_active_q, .forced_continuous_mode_q, .light_load_pulse_mode_q, .hiccup_active_q,
    .pg_warning_q, .output_good_flag_out_q, .output_good_flag_oe_n_q);
  sq_stage_model stage_u (.sys_clk, .high_side_en(high_side_en_q), .low_side_en(low_side_en_q),
    .ss_active(ss_ramp_active_q), .load_en, .load_val, .ss_ref_above_sense, .overvoltage_trip,
    .undervoltage_trip, .ov_warn, .uv_warn, .neg_ilim_hit, .vout);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Flags any fall of the output below its pre-charge level during soft start
  always @(posedge sys_clk) begin
    if (ss_ramp_active_q && vout < pre) begin
      dropped <= 1'b1;
    end
  end
  task automatic report_and_stop();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic pick(input int k);
    return k == 0 ? ss_ramp_active_q : (k == 1 ? output_good_flag_oe_n_q : hiccup_active_q);
  endfunction
  task automatic wait_for(input int k, input logic v);
    n = 0;
    while (pick(k) !== v) begin
      @(negedge sys_clk);
      n++;
      if (n > 20000) begin
        num_errors++;
        report_and_stop();
      end
    end
  endtask
  task automatic load(input logic [7:0] v);
    load_val = v;
    load_en = 1'b1;
    @(negedge sys_clk);
    load_en = 1'b0;
  endtask
  task automatic fault(input logic [7:0] v);
    wait_for(1, 1'b1);
    load(v);
    wait_for(2, 1'b1);
    check(output_good_flag_oe_n_q, 1'b0);
    wait_for(2, 1'b0);
    check(n + per + 2 >= HIC * per && n <= HIC * per + per + 2, 1'b1);
    @(negedge sys_clk);
    check(output_good_flag_oe_n_q, 1'b0);
    $display("fault %h done", v);
  endtask
  initial begin
    {rst_b, enable_in, program_mode_in, host_cfg_valid, host_light_load_en, load_en} = 6'h00;
    {softstart_lightload_strap, host_ssclk_sel, vout_range_sel} = 8'h00;
    load_val = 8'h00;
    pre = 8'h00;
    dropped = 1'b0;
    repeat (20) @(negedge sys_clk);
    rst_b = 1'b1;
    for (int i = 0; i < 12; i++) begin
      r = rows[i];
      enable_in = 1'b0;
      {softstart_lightload_strap, host_cfg_valid, host_light_load_en, host_ssclk_sel} = r[15:8];
      vout_range_sel = r[7:6];
      pre = 8'(i * 9);
      load(pre);
      repeat (2) @(negedge sys_clk);
      dropped = 1'b0;
      enable_in = 1'b1;
      wait_for(0, 1'b1);
      wait_for(0, 1'b0);
      per = 25 << r[5:4];
      exp_len = (SSB << (r[7:6] > 2 ? 2 : r[7:6])) * per;
      check(n + per + 2 >= exp_len && n <= exp_len + per + 2, 1'b1);
      wait_for(1, 1'b1);
      check(n + 2 >= OUTPUT_GOOD_FLAG && n <= OUTPUT_GOOD_FLAG + 2, 1'b1);
      repeat (2) @(negedge sys_clk);
      check(light_load_pulse_mode_q, r[0]);
      check(forced_continuous_mode_q, !r[0]);
      check({dropped, pg_pin}, 2'h1);
      $display("row %0d done", i);
    end
    fault(8'h78);
    fault(8'h46);
    wait_for(1, 1'b1);
    load(8'h65);
    repeat (3) @(negedge sys_clk);
    check({pg_warning_q, output_good_flag_oe_n_q}, 2'h2);
    load(8'h64);
    wait_for(1, 1'b1);
    check(n + 2 >= OUTPUT_GOOD_FLAG && n <= OUTPUT_GOOD_FLAG + 2, 1'b1);
    program_mode_in = 1'b1;
    repeat (3) @(negedge sys_clk);
    check(output_good_flag_oe_n_q, 1'b0);
    program_mode_in = 1'b0;
    wait_for(1, 1'b1);
    rst_b = 1'b0;
    repeat (2) @(negedge sys_clk);
    check({high_side_en_q, low_side_en_q, ss_ramp_active_q, forced_continuous_mode_q,
           light_load_pulse_mode_q, hiccup_active_q, pg_warning_q, output_good_flag_out_q,
           output_good_flag_oe_n_q}, 9'h020);
    rst_b = 1'b1;
    $display("special cases done");
    report_and_stop();
  end
endmodule // testbench
